// ==== bacs_defs.svh ====
// Purpose: Offsets, field positions and reset values of the acquisition
//          control and status block.
// Assumes: Byte address is base plus four times the register index.
// Notes:   Definitions only.
`ifndef BACS_DEFS_SVH
`define BACS_DEFS_SVH
// ==========================================================================
// Address map
`define BACS_BASE_BLOCKING    12'h200
`define BACS_BASE_NONBLOCKING 12'h300
`define BACS_IDX_CTL          12'h058
`define BACS_IDX_STAT_HI      12'h05a
`define BACS_IDX_IRQ_STATUS   12'h070
`define BACS_IDX_IRQ_CLEAR    12'h071
`define BACS_IDX_IRQ_ENABLE   12'h072
// ==========================================================================
// Control register fields
`define BACS_MASK_SHIFT       8
`define BACS_CTL_CLR_BIT      7
`define BACS_CTL_ALT_BIT      6
`define BACS_CTL_BRK_BIT      5
`define BACS_CTL_IRQE_BIT     4
`define BACS_CTL_RESET        7'h00
// ==========================================================================
// Status and interrupt fields
`define BACS_STAT_RESET       8'h00
`define BACS_IRQ_CUR_BIT      0
`define BACS_IRQ_BATTERY_SENSE_RESULT_BIT     1
`define BACS_IRQ_RESET        2'h0
`endif

// ==== bacs_pkg.sv ====
// Purpose: Types shared by the acquisition control and status block.
// Assumes: Field order matches the register bit order, msb first.
// Notes:   Constants live in bacs_defs.svh.
package bacs_pkg;
   // =======================================================================
   // Stored control bits, bit 6 down to bit 0.
   typedef struct packed {
      logic       alt_sense_select;
      logic       shunt_break_detect_enable;
      logic       measure_irq_enable;
      logic [3:0] chan_enable; // ext temp, int temp, voltage, shunt.
   } bacs_ctl_t;
   // =======================================================================
   // Upper status byte, bit 7 down to bit 0.
   typedef struct packed {
      logic       analog_supply_lowv_reset_flag;
      logic       gain_change_flag;
      logic       voltage_result_overrun_flag;
      logic       shunt_result_overrun_flag;
      logic [3:0] done_flags; // ext temp, int temp, voltage, shunt.
   } bacs_stat_t;
   // =======================================================================
   // Events from the measurement datapath, one-cycle pulses.
   typedef struct packed {
      logic [3:0] done;        // ext temp, int temp, voltage, shunt.
      logic       battery_sense_result_latch;  // New voltage result latched.
      logic       battery_sense_result_read;   // Software read the voltage result.
      logic       shunt_latch; // New shunt result latched.
      logic       shunt_read;  // Software read the shunt result.
      logic       gain_change; // Amplifier gain changed.
   } bacs_evt_t;
endpackage

// ==== bacs_ctrl.sv ====
// Purpose: Acquisition control register and upper status byte of a battery
//          sensor, reached over AHB-Lite, with a gated measurement interrupt.
// Assumes: One clock; datapath events are same-clock pulses; the analog
//          low-voltage cause is asynchronous and is synchronised here.
// Notes:   Zero wait states; response always OKAY.
// How it works
// - A control bit changes only when its mask bit eight higher is one.
// - Control at index 0x58, status at 0x5A, under both base addresses.
// - A masked one at bit 7 clears the charge accumulator.
// - Bit 6 selects the second battery input instead of the main one.
// - Bit 5 enables shunt break detection; status meaningless while off.
// - Bit 4 gates the current and voltage measurement interrupt.
// - Bits 3 to 0 enable ext temp, int temp, voltage, shunt channels.
// - Status bits clear on writing one, zero keeps them, reset to zero.
// - Status bit 7 marks a reset caused by analog supply low voltage.
// - Status bit 6 sets on every gain change until cleared.
// - Status bit 5 sets when the voltage result is overwritten.
// - Status bit 4 sets when the shunt result is overwritten.
// - Overwrite means a new result latched before the old one was read.
// - Status bits 3 to 0 set on each channel's measurement completion.
// - Gain, overwrite and temperature flags never raise the interrupt.
`timescale 1ns/1ps
`include "bacs_defs.svh"

module bacs_ctrl
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             clk_en,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic             hready,
   input  wire logic [31:0]      hwdata,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire bacs_pkg::bacs_evt_t evt,
   input  wire logic             analog_lowv_cause,
   output bacs_pkg::bacs_ctl_t   ctl,
   output logic                  charge_counter_clear,
   output logic                  irq
);
   import bacs_pkg::*;

   // =======================================================================
   // Address decode
   localparam logic [11:0] CTL_OFS   = 12'(`BACS_IDX_CTL << 2);
   localparam logic [11:0] STAT_OFS  = 12'(`BACS_IDX_STAT_HI << 2);
   localparam logic [11:0] IRQS_OFS  = 12'(`BACS_IDX_IRQ_STATUS << 2);
   localparam logic [11:0] IRQC_OFS  = 12'(`BACS_IDX_IRQ_CLEAR << 2);
   localparam logic [11:0] IRQE_OFS  = 12'(`BACS_IDX_IRQ_ENABLE << 2);

   typedef enum logic [2:0]
   {
      SEL_NONE = 3'b000,
      SEL_CTL  = 3'b001,
      SEL_STAT = 3'b010,
      SEL_IRQS = 3'b011,
      SEL_IRQC = 3'b100,
      SEL_IRQE = 3'b101
   } bacs_sel_t;

   bacs_ctl_t   ctl_reg;
   bacs_stat_t  stat_reg;
   logic [1:0]  irq_status_reg;
   logic [1:0]  irq_enable_reg;
   logic        clear_pulse_reg;
   logic [31:0] hrdata_reg;
   logic        wr_pend_reg;
   bacs_sel_t   wr_sel_reg;
   logic        battery_sense_result_unread_reg;
   logic        shunt_unread_reg;
   logic        lowv_meta_reg;
   logic        lowv_sync_reg;
   logic        lowv_prev_reg;
   logic        in_window;
   logic        addr_phase;
   bacs_sel_t   sel;
   logic        wr_ctl;
   logic        wr_stat;
   logic        wr_irqc;
   logic        wr_irqe;
   logic [15:0] wd;
   bacs_stat_t  stat_set;
   logic [1:0]  irq_set;

   assign addr_phase = hsel & hready & htrans[1];
   assign wd         = hwdata[15:0];

   // The low twelve address bits decode once the upper twenty are zero; the blocking flavour needs
   // no wait state here because the bus never stalls.
   assign in_window = (haddr[31:12] == 20'h00000);

   // Each register answers under both base addresses alike.
   always_comb
   begin
      sel = SEL_NONE;
      if (!in_window)
      begin
         sel = SEL_NONE;
      end
      else if (haddr[11:0] == `BACS_BASE_BLOCKING + CTL_OFS ||
               haddr[11:0] == `BACS_BASE_NONBLOCKING + CTL_OFS)
      begin
         sel = SEL_CTL;
      end
      else if (haddr[11:0] == `BACS_BASE_BLOCKING + STAT_OFS ||
               haddr[11:0] == `BACS_BASE_NONBLOCKING + STAT_OFS)
      begin
         sel = SEL_STAT;
      end
      else if (haddr[11:0] == `BACS_BASE_BLOCKING + IRQS_OFS ||
               haddr[11:0] == `BACS_BASE_NONBLOCKING + IRQS_OFS)
      begin
         sel = SEL_IRQS;
      end
      else if (haddr[11:0] == `BACS_BASE_BLOCKING + IRQC_OFS ||
               haddr[11:0] == `BACS_BASE_NONBLOCKING + IRQC_OFS)
      begin
         sel = SEL_IRQC;
      end
      else if (haddr[11:0] == `BACS_BASE_BLOCKING + IRQE_OFS ||
               haddr[11:0] == `BACS_BASE_NONBLOCKING + IRQE_OFS)
      begin
         sel = SEL_IRQE;
      end
   end

   // =======================================================================
   // Bus phases
   // Write address phase is remembered; the data arrives one cycle later.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_sel_reg  <= SEL_NONE;
      end
      else if (clk_en)
      begin
         wr_pend_reg <= addr_phase & hwrite;
         wr_sel_reg  <= sel;
      end
   end

   assign wr_ctl  = wr_pend_reg && wr_sel_reg == SEL_CTL;
   assign wr_stat = wr_pend_reg && wr_sel_reg == SEL_STAT;
   assign wr_irqc = wr_pend_reg && wr_sel_reg == SEL_IRQC;
   assign wr_irqe = wr_pend_reg && wr_sel_reg == SEL_IRQE;

   // Read data is captured in the address phase, so a read directly behind
   // a write to the same register would see the old value.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_reg <= 32'h00000000;
      end
      else if (clk_en && addr_phase && !hwrite)
      begin
         if (sel == SEL_CTL)
         begin
            hrdata_reg <= {25'h0000000, ctl_reg};
         end
         else if (sel == SEL_STAT)
         begin
            hrdata_reg <= {24'h000000, stat_reg};
         end
         else if (sel == SEL_IRQS)
         begin
            hrdata_reg <= {30'h00000000, irq_status_reg};
         end
         else if (sel == SEL_IRQE)
         begin
            hrdata_reg <= {30'h00000000, irq_enable_reg};
         end
         else
         begin
            hrdata_reg <= 32'h00000000;
         end
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // =======================================================================
   // Control register
   // Each low bit takes the written value only under its own mask bit.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctl_reg <= `BACS_CTL_RESET;
      end
      else if (clk_en && wr_ctl)
      begin
         for (int i = 0; i < `BACS_CTL_CLR_BIT; i++)
         begin
            if (wd[i + `BACS_MASK_SHIFT])
            begin
               ctl_reg[i] <= wd[i];
            end
         end
      end
   end

   // Accumulator clear is a one-cycle pulse and is never stored.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clear_pulse_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         clear_pulse_reg <= wr_ctl && wd[`BACS_CTL_CLR_BIT] &&
            wd[`BACS_CTL_CLR_BIT + `BACS_MASK_SHIFT];
      end
   end

   assign ctl                  = ctl_reg;
   assign charge_counter_clear = clear_pulse_reg;

   // =======================================================================
   // Low-voltage cause synchroniser and edge detect
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lowv_meta_reg <= 1'b0;
         lowv_sync_reg <= 1'b0;
         lowv_prev_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         lowv_meta_reg <= analog_lowv_cause;
         lowv_sync_reg <= lowv_meta_reg;
         lowv_prev_reg <= lowv_sync_reg;
      end
   end

   // =======================================================================
   // Overwrite tracking: a result stays unread until its read pulse.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         battery_sense_result_unread_reg  <= 1'b0;
         shunt_unread_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if (evt.battery_sense_result_latch || evt.battery_sense_result_read)
         begin
            battery_sense_result_unread_reg <= evt.battery_sense_result_latch;
         end
         if (evt.shunt_latch || evt.shunt_read)
         begin
            shunt_unread_reg <= evt.shunt_latch;
         end
      end
   end

   // =======================================================================
   // Status byte: setting beats a clear in the same cycle.
   always_comb
   begin
      stat_set = `BACS_STAT_RESET;
      stat_set.analog_supply_lowv_reset_flag =
         lowv_sync_reg & ~lowv_prev_reg;
      stat_set.gain_change_flag = evt.gain_change;
      stat_set.voltage_result_overrun_flag =
         evt.battery_sense_result_latch & battery_sense_result_unread_reg & ~evt.battery_sense_result_read;
      stat_set.shunt_result_overrun_flag =
         evt.shunt_latch & shunt_unread_reg & ~evt.shunt_read;
      stat_set.done_flags = evt.done;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stat_reg <= `BACS_STAT_RESET;
      end
      else if (clk_en)
      begin
         stat_reg <= (stat_reg & ~({8{wr_stat}} & wd[7:0])) |
            stat_set;
      end
   end

   // =======================================================================
   // Interrupt: only shunt and voltage completion feed it.
   always_comb
   begin
      irq_set = `BACS_IRQ_RESET;
      irq_set[`BACS_IRQ_CUR_BIT]  = evt.done[0];
      irq_set[`BACS_IRQ_BATTERY_SENSE_RESULT_BIT] = evt.done[1];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_status_reg <= `BACS_IRQ_RESET;
      end
      else if (clk_en)
      begin
         irq_status_reg <= (irq_status_reg & ~({2{wr_irqc}} & wd[1:0])) |
            irq_set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_enable_reg <= `BACS_IRQ_RESET;
      end
      else if (clk_en && wr_irqe)
      begin
         irq_enable_reg <= wd[1:0];
      end
   end

   // Level output, high while an enabled pending bit is set and allowed.
   assign irq = ctl_reg.measure_irq_enable &
      (|(irq_status_reg & irq_enable_reg));

endmodule // bacs_ctrl

// ==== bacs_ctrl_asserts.sv ====
// Purpose: Concurrent checks on the ports of bacs_ctrl.
// Assumes: Zero wait state slave; clk_en high during bus transfers.
// Notes:   Bound to every bacs_ctrl instance at the foot.
`timescale 1ns/1ps
`include "bacs_defs.svh"
module bacs_ctrl_asserts
(
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               clk_en,
   input wire logic               hsel,
   input wire logic [31:0]        haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic               hready,
   input wire logic [31:0]        hwdata,
   input wire logic [31:0]        hrdata,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire bacs_pkg::bacs_ctl_t ctl,
   input wire logic               charge_counter_clear,
   input wire logic               irq
);
   import bacs_pkg::*;
   logic hit;
   logic ap_wc;
   logic ap_rc;
   // =======================================================================
   // Helper: control register hit under either base.
   assign hit = hsel && hready && htrans[1] && clk_en &&
      (haddr[11:0] == `BACS_BASE_BLOCKING + (`BACS_IDX_CTL << 2) ||
       haddr[11:0] == `BACS_BASE_NONBLOCKING + (`BACS_IDX_CTL << 2));
   // Address phase remembered so the data phase can be judged.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_wc <= 1'b0;
         ap_rc <= 1'b0;
      end
      else
      begin
         ap_wc <= hit && hwrite;
         ap_rc <= hit && !hwrite;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // =======================================================================
   // Assertions.
   sequence s_clr_wr;
      ap_wc && hwdata[15] && hwdata[7];
   endsequence
   sequence s_clr_pulse;
      charge_counter_clear ##1 !charge_counter_clear;
   endsequence
   AST_CTL_MASKED: assert property (ap_wc |=> ctl ==
      (($past(hwdata[14:8]) & $past(hwdata[6:0])) |
       (~$past(hwdata[14:8]) & $past(ctl))))
      else $error("control bits ignore the write mask");
   AST_MASK_NONE: assert property (ap_wc && hwdata[14:8] == 7'h00
      |=> $stable(ctl)) else $error("unmasked write changed control");
   AST_CTL_HOLD: assert property (!ap_wc |=> $stable(ctl))
      else $error("control changed without a write");
   AST_CLR_PULSE: assert property (s_clr_wr ##1 !ap_wc |->
      s_clr_pulse) else $error("counter clear not one pulse");
   AST_CLR_CAUSE: assert property (charge_counter_clear |->
      $past(ap_wc && hwdata[15] && hwdata[7]))
      else $error("counter clear without masked one");
   AST_RD_CTL: assert property (ap_rc |->
      hrdata == {25'h0, $past(ctl)}) else $error("control read wrong");
   AST_IRQ_GATE: assert property (!ctl.measure_irq_enable &&
      !$past(ctl.measure_irq_enable) |-> !irq)
      else $error("irq while gate is off");
   AST_BUS_ZW: assert property (hsel && htrans[1] |=>
      hreadyout && !hresp) else $error("bus answer not ready okay");
endmodule // bacs_ctrl_asserts
bind bacs_ctrl bacs_ctrl_asserts i_chk (.hclk, .hresetn, .clk_en, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
   .ctl, .charge_counter_clear, .irq);

// ==== bacs_dpath_model.sv ====
// Purpose: Measurement datapath model feeding bacs_ctrl events.
// Assumes: Requests are one-cycle pulses from the bench.
// Notes:   Latch pulses come in the same cycle as the voltage and shunt done pulses.
`timescale 1ns/1ps
module bacs_dpath_model
(
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire bacs_pkg::bacs_evt_t req,
   input wire bacs_pkg::bacs_ctl_t ctl,
   input wire logic                charge_counter_clear,
   output bacs_pkg::bacs_evt_t     evt,
   output logic [7:0]              clr_seen
);
   import bacs_pkg::*;
   // Only enabled channels ever finish, so a disabled one stays silent.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         evt <= '0;
      else
      begin
         evt.done        <= req.done & ctl.chan_enable;
         evt.battery_sense_result_latch  <= req.done[1] & ctl.chan_enable[1];
         evt.battery_sense_result_read   <= req.battery_sense_result_read;
         evt.shunt_latch <= req.done[0] & ctl.chan_enable[0];
         evt.shunt_read  <= req.shunt_read;
         evt.gain_change <= req.gain_change;
      end
   end
   // Each clear pulse is counted for the bench.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         clr_seen <= 8'h00;
      else if (charge_counter_clear)
         clr_seen <= clr_seen + 8'h01;
   end
endmodule // bacs_dpath_model

// ==== bacs_ctrl_bench.sv ====
// Purpose: Self-checking bench of bacs_ctrl over AHB-Lite.
// Assumes: Zero wait states, yet every wait is bounded.
// Notes:   Read expectations queue up and a monitor compares them.
`timescale 1ns/1ps
`include "bacs_defs.svh"
module bacs_ctrl_bench;
   import bacs_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        ccc, irq, lowv, dph, ce;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  clr_seen;
   logic [15:0] d, e;
   logic [31:0] q[$];
   bacs_evt_t   req, evt;
   bacs_ctl_t   ctl;
   int          bad_count, tests_run, seed, i, n_clr;
   localparam logic [11:0] B0 = `BACS_BASE_BLOCKING;
   localparam logic [11:0] B1 = `BACS_BASE_NONBLOCKING;
   function automatic logic [31:0] ad(input logic [11:0] b, x);
      return {20'h0, b + (x << 2)};
   endfunction
   // Clock of 4 ns.
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   bacs_ctrl i_dut (.hclk, .hresetn, .clk_en(ce), .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
      .hresp, .evt, .analog_lowv_cause(lowv), .ctl,
      .charge_counter_clear(ccc), .irq);
   bacs_dpath_model i_dp (.hclk, .hresetn, .req, .ctl,
      .charge_counter_clear(ccc), .evt, .clr_seen);
   task automatic chk(input string n, input logic [31:0] g, x);
      tests_run++;
      if (g !== x)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Bounded wait for hready; a hang ends the run.
   task automatic hwait;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready_low())
      begin
         n++;
         if (n > 20)
         begin
            bad_count++;
            complete_run;
         end
         @(posedge hclk);
      end
   endtask
   function automatic bit hready_low();
      return hreadyout !== 1'b1;
   endfunction
   task automatic xfer(input logic w, input logic [31:0] a, dat, x);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= a;
      hsize  <= 3'b010;
      hwait;
      htrans <= 2'b00;
      hwdata <= dat;
      dph    <= !w;
      if (!w)
         q.push_back(x);
      hwait;
      dph <= 1'b0;
   endtask
   task automatic ev(input bacs_evt_t r);
      @(posedge hclk);
      req <= r;
      @(posedge hclk);
      req <= '0;
   endtask
   // Monitor takes the oldest note whenever read data stands.
   always @(posedge hclk)
   begin
      if (dph === 1'b1)
         chk("hrdata", hrdata, q.pop_front());
   end
   initial
   begin
      seed = 72;
      bad_count = 0;
      tests_run = 0;
      n_clr = 0;
      e = 16'h0;
      {hresetn, hsel, hwrite, lowv, dph, htrans} = '0;
      ce = 1'b1;
      {haddr, hwdata, hsize, req} = '0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, ad(B0, `BACS_IDX_CTL), 0, 0);
      xfer(0, ad(B1, `BACS_IDX_STAT_HI), 0, 0);
      xfer(0, ad(B0, `BACS_IDX_IRQ_ENABLE), 0, 0);
      xfer(0, ad(B0, 12'h010), 0, 0);
      chk("irq", irq, 0);
      $display("reset test done");
      xfer(1, ad(B0, `BACS_IDX_CTL), 32'h8080, 0);
      xfer(1, ad(B1, `BACS_IDX_CTL), 32'h0080, 0);
      n_clr = 1;
      for (i = 0; i < 12; i++)
      begin
         d = 16'($random(seed));
         e[6:0] = (d[14:8] & d[6:0]) | (~d[14:8] & e[6:0]);
         n_clr += d[15] & d[7];
         xfer(1, ad(i[0] ? B1 : B0, `BACS_IDX_CTL), {16'h0, d}, 0);
         xfer(0, ad(i[1] ? B1 : B0, `BACS_IDX_CTL), 0, e[6:0]);
         chk("ctl", ctl, e[6:0]);
      end
      chk("clears", clr_seen, n_clr[7:0]);
      $display("mask test done");
      xfer(1, ad(B0, `BACS_IDX_CTL), 32'h7f1f, 0);
      xfer(1, ad(B0, `BACS_IDX_IRQ_ENABLE), 32'h3, 0);
      ev(9'h1e0);
      xfer(0, ad(B0, `BACS_IDX_STAT_HI), 0, 32'h0f);
      chk("irq", irq, 1);
      // The cause needs three edges through the synchroniser, so it is
      // raised well before the status read that expects it.
      lowv <= 1'b1;
      ev(9'h040);
      ev(9'h002);
      ev(9'h020);
      ev(9'h001);
      xfer(0, ad(B1, `BACS_IDX_STAT_HI), 0, 32'hef);
      xfer(1, ad(B0, `BACS_IDX_STAT_HI), 32'h0f, 0);
      xfer(0, ad(B0, `BACS_IDX_STAT_HI), 0, 32'he0);
      xfer(1, ad(B0, `BACS_IDX_IRQ_CLEAR), 32'h3, 0);
      ev(9'h181);
      xfer(0, ad(B0, `BACS_IDX_IRQ_STATUS), 0, 0);
      chk("irq", irq, 0);
      xfer(1, ad(B0, `BACS_IDX_CTL), 32'h1000, 0);
      ev(9'h020);
      xfer(0, ad(B0, `BACS_IDX_IRQ_STATUS), 0, 32'h1);
      chk("irq", irq, 0);
      xfer(1, ad(B1, `BACS_IDX_CTL), 32'h1010, 0);
      xfer(0, ad(B0, `BACS_IDX_CTL), 0, 32'h1f);
      chk("irq", irq, 1);
      // Second shunt latch while still unread marks the shunt overrun.
      xfer(0, ad(B1, `BACS_IDX_STAT_HI), 0, 32'hfd);
      xfer(1, ad(B1, `BACS_IDX_STAT_HI), 32'hff, 0);
      // Events while the clock enable is low must leave no trace.
      ce <= 1'b0;
      ev(9'h021);
      repeat (2) @(posedge hclk);
      ce <= 1'b1;
      xfer(0, ad(B0, `BACS_IDX_STAT_HI), 0, 32'h00);
      $display("event test done");
      complete_run;
   end
endmodule // bacs_ctrl_bench
